// file: logic/sert_pkg.sv
/*
 * Constants, bit layouts and command codes of the status event tree.
 * Assumes a message parser outside turns program messages into one
 * command code plus a binary integer, and formats answers as decimal.
 */
package sert_pkg;

    // Register width and reset value of every enable mask
    localparam int REG_W = 16;
    localparam logic [15:0] MASK_RST = 16'h0000;

    // Operation in progress status bit positions
    localparam int OP_RECALL_BIT = 11;
    localparam int OP_FAIL_BIT = 10;
    localparam int OP_PHASE_BIT = 9;
    localparam int OP_OUTPUT_BIT = 8;
    localparam int OP_RANGE_BIT = 2;

    // Grouped event summary bit positions
    localparam int XE_W = 4;
    localparam int XE_WARN_BIT = 3;
    localparam int XE_OPER_BIT = 2;
    localparam int XE_FAIL_BIT = 1;
    localparam int XE_OVL_BIT = 0;

    // Warning event bit positions
    localparam int WN_MONITOR_BIT = 14;
    localparam int WN_MEAS_PHASE_BIT = 11;
    localparam int WN_AC_PHASE_BIT = 9;
    localparam int WN_SYNC_BIT = 3;
    localparam int WN_PHASE_MODE_BIT = 2;
    localparam int WN_OUT_OFF_BIT = 1;
    localparam int WN_PWR_OFF_BIT = 0;

    // Status byte positions of the two summaries made here
    localparam int SB_W = 8;
    localparam int SB_OPER_BIT = 7;
    localparam int SB_GROUP_BIT = 1;

    // Commands decoded from program messages
    typedef enum logic [3:0] {
        CMD_IDLE = 4'h0,
        CMD_QUERY_OPERATION_STATUS = 4'h1,
        CMD_SET_OPERATION_MASK = 4'h2,
        CMD_QUERY_OPERATION_MASK = 4'h3,
        CMD_QUERY_GROUPED_EVENTS = 4'h4,
        CMD_SET_GROUPED_EVENT_MASK = 4'h5,
        CMD_QUERY_GROUPED_EVENT_MASK = 4'h6,
        CMD_QUERY_WARNING_EVENTS = 4'h7,
        CMD_SET_WARNING_MASK = 4'h8,
        CMD_QUERY_WARNING_MASK = 4'h9,
        CMD_CLEAR_STATUS = 4'hA
    } sert_cmd_t;

endpackage

// file: logic/sert_edge_latch.sv
/*
 * Sticky event bits set on a rising source, cleared by a strobe.
 * Assumes sources and clears come from logic on the same clock.
 */
`timescale 1ns/1ns
module sert_edge_latch #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] src_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] bits_out
);
    logic [W-1:0] prev_q;
    logic [W-1:0] bits_q;
    logic [W-1:0] bits_d;

    // Width must hold at least one bit
    if (W < 1) begin : g_bad_w
        $error("sert_edge_latch: W must be at least 1");
    end

    // Only a fresh rise sets; a held level never re-arms a cleared bit
    always_comb begin
        bits_d = (src_in & ~prev_q) | (bits_q & ~clr_in); // [RULE18]
    end

    // Previous source level for edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= '0;
        end else begin
            prev_q <= src_in;
        end
    end

    // Event storage; set term wins over a coincident clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bits_q <= '0;
        end else begin
            bits_q <= bits_d;
        end
    end

    assign bits_out = bits_q;
endmodule // sert_edge_latch

// file: logic/sert_status_tree.sv
/*
 * Status event tree: operation status, grouped events and warning
 * events with their enable masks, and two status byte summaries.
 * Assumes a parser outside presents one decoded command per cycle and
 * that all condition inputs come from logic on clk_in.
 */
// Behaviour
// [RULE1] Operation status bits follow their activity conditions only.
// [RULE2] Operation bits 11,10,9,8,2 used; all others read zero.
// [RULE3] Operation summary high when any status bit and its mask match.
// [RULE4] Masks reset to zero and are written and read as one integer.
// [RULE5] Grouped event bit set only when its source OR rises.
// [RULE6] A register read clears only its own grouped event bit.
// [RULE7] Clear status empties grouped and warning event registers.
// [RULE8] Grouped bits: 3 warning, 2 operation, 1 fail, 0 overload.
// [RULE9] Grouped summary high when any grouped bit and its mask match.
// [RULE10] Warning query returns contents, then clears all warning bits.
// [RULE11] Enabled warning bits feed grouped event bit three.
// [RULE12] Warning bits 14,11,9,3,2 latch on their phase and sync events.
// [RULE13] Warning bit 1 on protective output off, bit 0 on power cut.
// [RULE14] Every query answers with the register value as an integer.
// [RULE15] Host uses distinct query and setting messages per register.
// [RULE16] Operation summary sits at status byte bit 7.
// [RULE17] Grouped summary sits at status byte bit 1.
// [RULE18] Summaries combinational from registers; set beats clear.
`timescale 1ns/1ns
module sert_status_tree #(
    parameter int REG_W = sert_pkg::REG_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire sert_pkg::sert_cmd_t cmd_code_in,
    input wire logic [15:0] cmd_data_in,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    input wire logic recall_busy_in,
    input wire logic fail_cause_in,
    input wire logic phase_switch_busy_in,
    input wire logic output_switch_busy_in,
    input wire logic range_switch_busy_in,
    input wire logic monitor_reset_in,
    input wire logic meas_phase_revert_in,
    input wire logic ac_phase_volt_in,
    input wire logic sync_release_in,
    input wire logic phase_mode_switched_in,
    input wire logic prot_output_off_in,
    input wire logic prot_power_off_in,
    input wire logic oper_event_any_in,
    input wire logic fail_event_any_in,
    input wire logic ovl_event_any_in,
    input wire logic oper_event_read_in,
    input wire logic fail_event_read_in,
    input wire logic ovl_event_read_in,
    output logic operation_summary_bit_out,
    output logic grouped_event_summary_bit_out,
    output logic [7:0] status_byte_part_out
);
    import sert_pkg::*;

    // Bit 14 is the highest position this tree must hold
    if (REG_W != 16) begin : g_bad_w
        $error("sert_status_tree: REG_W must be 16");
    end

    // True when any bit is set in both words
    function automatic logic masked_any(input logic [15:0] bits,
                                        input logic [15:0] mask);
        masked_any = |(bits & mask);
    endfunction

    logic [15:0] op_map;
    logic [15:0] op_status_q;
    logic [15:0] op_mask_q;
    logic [15:0] grp_mask_q;
    logic [15:0] warn_mask_q;
    logic [15:0] warn_raw;
    logic [15:0] warn_bits;
    logic [15:0] warn_clr;
    logic [XE_W-1:0] grp_src;
    logic [XE_W-1:0] grp_clr;
    logic [XE_W-1:0] grp_bits;
    logic [15:0] grp_word;
    logic warn_src_any;
    logic is_cls;
    logic is_warn_read;
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;
    logic [15:0] rsp_data_d;
    logic rsp_hit;

    // Command strobes
    assign is_cls = cmd_valid_in && (cmd_code_in == CMD_CLEAR_STATUS);
    assign is_warn_read = cmd_valid_in
        && (cmd_code_in == CMD_QUERY_WARNING_EVENTS);

    // Activity conditions onto their status positions
    always_comb begin
        op_map = 16'h0000; // [RULE2]
        op_map[OP_RECALL_BIT] = recall_busy_in;
        op_map[OP_FAIL_BIT] = fail_cause_in;
        op_map[OP_PHASE_BIT] = phase_switch_busy_in;
        op_map[OP_OUTPUT_BIT] = output_switch_busy_in;
        op_map[OP_RANGE_BIT] = range_switch_busy_in;
    end

    // Status is a plain copy; no command can clear it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_status_q <= 16'h0000;
        end else begin
            op_status_q <= op_map; // [RULE1]
        end
    end

    // Operation mask takes the whole written integer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_mask_q <= MASK_RST; // [RULE4]
        end else if (cmd_valid_in
                     && cmd_code_in == CMD_SET_OPERATION_MASK) begin
            op_mask_q <= cmd_data_in; // [RULE4]
        end
    end

    // Grouped event mask
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            grp_mask_q <= MASK_RST; // [RULE4]
        end else if (cmd_valid_in
                     && cmd_code_in == CMD_SET_GROUPED_EVENT_MASK) begin
            grp_mask_q <= cmd_data_in; // [RULE4]
        end
    end

    // Warning event mask
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            warn_mask_q <= MASK_RST; // [RULE4]
        end else if (cmd_valid_in
                     && cmd_code_in == CMD_SET_WARNING_MASK) begin
            warn_mask_q <= cmd_data_in; // [RULE4]
        end
    end

    // Warning causes onto their positions; unused bits stay low
    always_comb begin
        warn_raw = 16'h0000;
        warn_raw[WN_MONITOR_BIT] = monitor_reset_in; // [RULE12]
        warn_raw[WN_MEAS_PHASE_BIT] = meas_phase_revert_in; // [RULE12]
        warn_raw[WN_AC_PHASE_BIT] = ac_phase_volt_in; // [RULE12]
        warn_raw[WN_SYNC_BIT] = sync_release_in; // [RULE12]
        warn_raw[WN_PHASE_MODE_BIT] = phase_mode_switched_in; // [RULE12]
        warn_raw[WN_OUT_OFF_BIT] = prot_output_off_in; // [RULE13]
        warn_raw[WN_PWR_OFF_BIT] = prot_power_off_in; // [RULE13]
    end

    // Read or clear status empties the whole warning register
    assign warn_clr = {16{is_warn_read | is_cls}}; // [RULE10] [RULE7]

    // Warning latch: a cause held high latches once, not repeatedly
    sert_edge_latch #(
        .W(16)
    ) u_warn (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .src_in(warn_raw),
        .clr_in(warn_clr),
        .bits_out(warn_bits)
    );

    // Enabled warnings summarise into grouped bit three
    assign warn_src_any = masked_any(warn_bits, warn_mask_q); // [RULE11]

    // Grouped sources and per-register clears
    always_comb begin
        grp_src = '0;
        grp_clr = '0;
        grp_src[XE_WARN_BIT] = warn_src_any; // [RULE8]
        grp_src[XE_OPER_BIT] = oper_event_any_in; // [RULE8]
        grp_src[XE_FAIL_BIT] = fail_event_any_in; // [RULE8]
        grp_src[XE_OVL_BIT] = ovl_event_any_in; // [RULE8]
        grp_clr[XE_WARN_BIT] = is_warn_read | is_cls; // [RULE6] [RULE7]
        grp_clr[XE_OPER_BIT] = oper_event_read_in | is_cls; // [RULE6]
        grp_clr[XE_FAIL_BIT] = fail_event_read_in | is_cls; // [RULE6]
        grp_clr[XE_OVL_BIT] = ovl_event_read_in | is_cls; // [RULE6]
    end

    // Grouped bits set on a rising OR, set beats clear
    sert_edge_latch #(
        .W(XE_W)
    ) u_grp ( // [RULE5] [RULE18]
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .src_in(grp_src),
        .clr_in(grp_clr),
        .bits_out(grp_bits)
    );

    // Bits 4 to 15 of the grouped register read zero
    assign grp_word = {{(16 - XE_W){1'b0}}, grp_bits}; // [RULE8]

    // Summaries straight from stored bits and masks
    assign operation_summary_bit_out =
        masked_any(op_status_q, op_mask_q); // [RULE3] [RULE18]
    assign grouped_event_summary_bit_out =
        masked_any(grp_word, grp_mask_q); // [RULE9] [RULE18]

    // Status byte slice; other positions belong to other logic
    always_comb begin
        status_byte_part_out = 8'h00;
        status_byte_part_out[SB_OPER_BIT] =
            operation_summary_bit_out; // [RULE16]
        status_byte_part_out[SB_GROUP_BIT] =
            grouped_event_summary_bit_out; // [RULE17]
    end

    // Query decode; values are binary integers for decimal formatting
    always_comb begin
        rsp_hit = 1'b1;
        rsp_data_d = 16'h0000;
        case (cmd_code_in)
            CMD_QUERY_OPERATION_STATUS: rsp_data_d = op_status_q; // [RULE14]
            CMD_QUERY_OPERATION_MASK: rsp_data_d = op_mask_q;
            CMD_QUERY_GROUPED_EVENTS: rsp_data_d = grp_word;
            CMD_QUERY_GROUPED_EVENT_MASK: rsp_data_d = grp_mask_q;
            CMD_QUERY_WARNING_EVENTS: rsp_data_d = warn_bits; // [RULE10]
            CMD_QUERY_WARNING_MASK: rsp_data_d = warn_mask_q;
            default: rsp_hit = 1'b0;
        endcase
    end

    // Answer one cycle after the query; pre-clear contents are sampled
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= cmd_valid_in && rsp_hit; // [RULE14]
        end
    end

    // Answer data holds until the next query replaces it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_data_q <= 16'h0000;
        end else if (cmd_valid_in && rsp_hit) begin
            rsp_data_q <= rsp_data_d; // [RULE14]
        end
    end

    assign rsp_valid_out = rsp_valid_q;
    assign rsp_data_out = rsp_data_q;

    // Checks on the tree
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Query followed by its answer
    sequence s_warn_query;
        is_warn_read;
    endsequence

    sequence s_answer;
        rsp_valid_out;
    endsequence

    a_op_status_track: assert property ( // [RULE1]
        1'b1 |=> op_status_q == $past(op_map))
        else $error("operation status lost its condition");

    a_op_unused_zero: assert property ( // [RULE2]
        (op_status_q & 16'hF0FB) == 16'h0000)
        else $error("unused operation bit set");

    a_op_summary_bit: assert property ( // [RULE3]
        status_byte_part_out[7] == |(op_status_q & op_mask_q))
        else $error("operation summary wrong");

    a_mask_write_back: assert property ( // [RULE4]
        cmd_valid_in && cmd_code_in == CMD_SET_WARNING_MASK
        ##1 cmd_valid_in && cmd_code_in == CMD_QUERY_WARNING_MASK
        |=> rsp_valid_out && rsp_data_out == $past(cmd_data_in, 2))
        else $error("warning mask readback wrong");

    a_grp_rise_sets: assert property ( // [RULE5]
        $rose(oper_event_any_in) |=> grp_bits[2])
        else $error("grouped bit missed a rise");

    a_grp_level_holds: assert property ( // [RULE5]
        !grp_bits[1] && $stable(fail_event_any_in) |=> !grp_bits[1])
        else $error("grouped bit set by a level");

    a_warn_read_own_bit: assert property ( // [RULE6]
        is_warn_read && !fail_event_read_in && !is_cls && grp_bits[1]
        |=> grp_bits[1])
        else $error("warning read cleared another bit");

    a_warn_read_clears: assert property ( // [RULE6]
        is_warn_read && !$rose(grp_src[3]) ##1 !$rose(grp_src[3])
        |-> !grp_bits[3])
        else $error("grouped warning bit not cleared");

    a_cls_empties: assert property ( // [RULE7]
        is_cls && (warn_raw & ~$past(warn_raw)) == 16'h0000
        |=> warn_bits == 16'h0000)
        else $error("clear status left warning bits");

    a_grp_upper_zero: assert property ( // [RULE8]
        cmd_valid_in && cmd_code_in == CMD_QUERY_GROUPED_EVENTS
        |=> rsp_data_out[15:4] == 12'h000)
        else $error("grouped upper bits not zero");

    a_grp_summary_bit: assert property ( // [RULE9]
        status_byte_part_out[1] == |(grp_word & grp_mask_q))
        else $error("grouped summary wrong");

    a_warn_read_return: assert property ( // [RULE10]
        s_warn_query |=> s_answer and rsp_data_out == $past(warn_bits))
        else $error("warning query returned wrong value");

    a_warn_feeds_grp: assert property ( // [RULE11]
        $rose(|(warn_bits & warn_mask_q)) |=> grp_bits[3])
        else $error("enabled warning did not reach grouped bit");

    a_warn_cause_latch: assert property ( // [RULE12]
        $rose(sync_release_in) |=> warn_bits[3])
        else $error("sync release not latched");

    a_power_cut_latch: assert property ( // [RULE13]
        $rose(prot_power_off_in) ##1 !(is_warn_read || is_cls)
        |-> warn_bits[0] [*2])
        else $error("power cut not latched");

    a_query_answers: assert property ( // [RULE14]
        cmd_valid_in && cmd_code_in == CMD_QUERY_OPERATION_STATUS
        |=> rsp_valid_out && rsp_data_out == $past(op_status_q))
        else $error("status query not answered");

    a_set_wins_clear: assert property ( // [RULE18]
        is_cls && $rose(prot_output_off_in) |=> warn_bits[1])
        else $error("event lost to a coincident clear");

endmodule // sert_status_tree

// file: bench/sert_host_model.sv
/*
 * Remote host controller model: issues decoded program messages to the
 * status event tree and collects the answers to queries.
 * Assumes the bench calls its tasks and that all timing is on clk_in.
 */
`timescale 1ns/1ns
module sert_host_model (
    input wire logic clk_in,
    input wire logic rsp_valid_in,
    input wire logic [15:0] rsp_data_in,
    output logic cmd_valid_out,
    output sert_pkg::sert_cmd_t cmd_code_out,
    output logic [15:0] cmd_data_out
);
    import sert_pkg::*;

    // Idle message port until the first request
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = CMD_IDLE;
        cmd_data_out = 16'h0000;
    end

    // One message per call, each register with its own code
    task automatic send(input sert_cmd_t code, input logic [15:0] data);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_data_out = data;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_code_out = CMD_IDLE;
        cmd_data_out = ~data; // Stale data must not be reused
    endtask

    // Poll a few cycles for the one-cycle answer; none leaves unknown
    task automatic collect(output logic [15:0] rsp);
        int n;
        rsp = 16'hXXXX;
        for (n = 0; n < 4; n++) begin
            if (rsp_valid_in === 1'b1) begin
                rsp = rsp_data_in;
                break;
            end
            @(negedge clk_in);
        end
    endtask

    // Query and wait a bounded time for the one-cycle answer
    task automatic query(input sert_cmd_t code, output logic [15:0] rsp);
        send(code, 16'h0000);
        collect(rsp);
    endtask

    // Setting then its query on the very next cycle
    task automatic set_query(input sert_cmd_t set_code,
                             input logic [15:0] data,
                             input sert_cmd_t code,
                             output logic [15:0] rsp);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = set_code;
        cmd_data_out = data;
        @(negedge clk_in);
        cmd_code_out = code;
        cmd_data_out = 16'h0000;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_code_out = CMD_IDLE;
        cmd_data_out = ~data;
        collect(rsp);
    endtask
endmodule // sert_host_model

// file: bench/sert_status_tree_tb.sv
/*
 * Self-checking bench of the status event tree: masks, operation
 * status, warning latching, grouped events and status byte summaries.
 * Assumes the host model drives messages and the bench drives causes.
 */
`timescale 1ns/1ns
module sert_status_tree_tb;
    import sert_pkg::*;

    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid;
    sert_cmd_t cmd_code;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [4:0] op_c = 5'h00;
    logic [6:0] wn_c = 7'h00;
    logic [2:0] any_c = 3'h0;
    logic [2:0] rd_c = 3'h0;
    logic [7:0] sb;
    logic op_sum;
    logic grp_sum;
    int err_total = 0;
    int checks_done = 0;
    logic [15:0] opw [5] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100,
                             16'h0004};
    logic [15:0] wnw [7] = '{16'h4000, 16'h0800, 16'h0200, 16'h0008,
                             16'h0004, 16'h0002, 16'h0001};

    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    sert_host_model sert_host_model_inst (.clk_in(clk_in),
        .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
        .cmd_data_out(cmd_data));

    sert_status_tree sert_status_tree_inst (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .cmd_data_in(cmd_data),
        .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
        .recall_busy_in(op_c[0]), .fail_cause_in(op_c[1]),
        .phase_switch_busy_in(op_c[2]), .output_switch_busy_in(op_c[3]),
        .range_switch_busy_in(op_c[4]), .monitor_reset_in(wn_c[0]),
        .meas_phase_revert_in(wn_c[1]), .ac_phase_volt_in(wn_c[2]),
        .sync_release_in(wn_c[3]), .phase_mode_switched_in(wn_c[4]),
        .prot_output_off_in(wn_c[5]), .prot_power_off_in(wn_c[6]),
        .oper_event_any_in(any_c[0]), .fail_event_any_in(any_c[1]),
        .ovl_event_any_in(any_c[2]), .oper_event_read_in(rd_c[0]),
        .fail_event_read_in(rd_c[1]), .ovl_event_read_in(rd_c[2]),
        .operation_summary_bit_out(op_sum),
        .grouped_event_summary_bit_out(grp_sum),
        .status_byte_part_out(sb));

    // Single compare point; unknowns never match
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input sert_cmd_t code, input logic [15:0] exp);
        logic [15:0] v;
        sert_host_model_inst.query(code, v);
        check(code.name(), v, exp);
    endtask

    // Mask setting and readback back to back
    task automatic rd_set(input sert_cmd_t set_code,
                          input logic [15:0] data, input sert_cmd_t code);
        logic [15:0] v;
        sert_host_model_inst.set_query(set_code, data, code, v);
        check(code.name(), v, data);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog, well beyond the 170 or so cycles of the tests
    initial begin
        #80000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        // Masks power up as zero, then write and read back
        rd(CMD_QUERY_OPERATION_MASK, MASK_RST);
        rd(CMD_QUERY_GROUPED_EVENT_MASK, MASK_RST);
        rd(CMD_QUERY_WARNING_MASK, MASK_RST);
        sert_host_model_inst.send(CMD_SET_OPERATION_MASK, 16'h0F04);
        sert_host_model_inst.send(CMD_SET_GROUPED_EVENT_MASK, 16'h000F);
        sert_host_model_inst.send(CMD_SET_WARNING_MASK, 16'hFFFF);
        rd(CMD_QUERY_OPERATION_MASK, 16'h0F04);
        rd(CMD_QUERY_GROUPED_EVENT_MASK, 16'h000F);
        rd(CMD_QUERY_WARNING_MASK, 16'hFFFF);
        // Each activity shows while busy and drops when done
        for (int i = 0; i < 5; i++) begin
            op_c = 5'(1 << i);
            wait_n(2);
            rd(CMD_QUERY_OPERATION_STATUS, opw[i]);
            check("status byte", {8'h00, sb}, 16'h0080);
            check("op summary", {15'h0000, op_sum}, 16'h0001);
            op_c = 5'h00;
            wait_n(2);
            rd(CMD_QUERY_OPERATION_STATUS, 16'h0000);
            check("status byte", {8'h00, sb}, 16'h0000);
            check("op summary", {15'h0000, op_sum}, 16'h0000);
        end
        // Warning causes latch, read returns then clears
        for (int i = 0; i < 7; i++) begin
            wn_c = 7'(1 << i);
            wait_n(1);
            wn_c = 7'h00;
            wait_n(2);
            rd(CMD_QUERY_WARNING_EVENTS, wnw[i]);
            rd(CMD_QUERY_WARNING_EVENTS, 16'h0000);
        end
        // Only warning bit 3 enabled from here until the mid-run reset
        rd_set(CMD_SET_WARNING_MASK, 16'h0008,
               CMD_QUERY_WARNING_MASK);
        // Grouped events: rise sets, held level does not re-set
        sert_host_model_inst.send(CMD_CLEAR_STATUS, 16'h0000);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0000);
        // A masked warning must not reach grouped bit three
        wn_c[6] = 1'b1;
        wait_n(1);
        wn_c[6] = 1'b0;
        wait_n(2);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0000);
        rd(CMD_QUERY_WARNING_EVENTS, 16'h0001);
        wn_c[3] = 1'b1;
        wait_n(1);
        wn_c[3] = 1'b0;
        wait_n(3);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0008);
        check("status byte", {8'h00, sb}, 16'h0002);
        check("grp summary", {15'h0000, grp_sum}, 16'h0001);
        any_c = 3'h7;
        wait_n(3);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h000F);
        rd_c[0] = 1'b1;
        wait_n(1);
        rd_c[0] = 1'b0;
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h000B);
        rd(CMD_QUERY_WARNING_EVENTS, 16'h0008);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0003);
        rd_c[1] = 1'b1;
        wait_n(1);
        rd_c[1] = 1'b0;
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0001);
        sert_host_model_inst.send(CMD_CLEAR_STATUS, 16'h0000);
        wait_n(2);
        rd(CMD_QUERY_GROUPED_EVENTS, 16'h0000);
        check("status byte", {8'h00, sb}, 16'h0000);
        check("grp summary", {15'h0000, grp_sum}, 16'h0000);
        any_c = 3'h0;
        // A cause rising with clear status must survive
        fork
            sert_host_model_inst.send(CMD_CLEAR_STATUS, 16'h0000);
            begin
                @(negedge clk_in);
                wn_c[3] = 1'b1;
                wn_c[5] = 1'b1;
            end
        join
        wn_c = 7'h00;
        wait_n(2);
        rd(CMD_QUERY_WARNING_EVENTS, 16'h000A);
        // Reset in mid-run returns the masks to zero
        rst_n_in = 1'b0;
        wait_n(2);
        rst_n_in = 1'b1;
        rd(CMD_QUERY_WARNING_MASK, MASK_RST);
        rd(CMD_QUERY_GROUPED_EVENT_MASK, MASK_RST);
        summarize();
    end
endmodule // sert_status_tree_tb
